// [logic/ipl_pkg.sv]
// Purpose: Shared constants and types for the interrupt pin output and hold-mode block.
// Assumes: REF_CLK at 250 MHz; registers reached through a plain byte register port.
// Notes: Pin index 0 is the first interrupt pin, index 1 the second.
// Overview of operation
// - Output config bit 7 enables driving the second interrupt pin; clear disables it.
// - Output config bit 3 enables driving the first interrupt pin; clear disables it.
// - Bits 6 and 2 pick push-pull (0) or open-drain (1) while driving.
// - Bit 5 sets second pin polarity for output, or for trigger input when undriven.
// - Bit 1 sets first pin polarity for output, or for trigger input when undriven.
// - Frame tagging from a pin ignores that pin's polarity bit.
// - Bits 4 and 0 choose edge (1) or level (0) sensing for input use.
// - Hold register bits 5 and 4 enable input sampling on second and first pin.
// - Hold code 0 follows the condition; code 15 keeps the interrupt asserted.
// - Codes 1 to 14 hold for 312.5us doubling per step up to 2.56s.
// - New-data, orientation and flat interrupts never use latched or timed hold.
// - Both registers reset to zero: pins undriven, inputs off, non-latched.
package ipl_pkg;

    localparam logic [7:0] IPL_ADDR_OUT_CFG = 8'h53;
    localparam logic [7:0] IPL_ADDR_HOLD = 8'h54;
    localparam logic [7:0] IPL_OUT_CFG_RST = 8'h00;
    localparam logic [7:0] IPL_HOLD_RST = 8'h00;
    localparam logic [7:0] IPL_HOLD_RW_MASK = 8'h3F;
    localparam logic [3:0] IPL_MODE_NONLATCH = 4'h0;
    localparam logic [3:0] IPL_MODE_LATCHED = 4'hF;
    localparam logic [3:0] IPL_MODE_STEP = 4'h1;

    // Shortest timed hold in picoseconds and the clock period that counts it.
    localparam int IPL_HOLD_BASE_PS = 312500000;
    localparam int IPL_CLK_PERIOD_PS = 4000;
    localparam int IPL_HOLD_BASE_CYC = IPL_HOLD_BASE_PS / IPL_CLK_PERIOD_PS;

    // Layout of the pin output configuration register, bit 7 first.
    typedef struct packed {
        logic b_drive;
        logic b_open_drain;
        logic b_polarity;
        logic b_edge;
        logic a_drive;
        logic a_open_drain;
        logic a_polarity;
        logic a_edge;
    } ipl_out_cfg_t;

    // Layout of the hold-mode and input register, bit 7 first.
    typedef struct packed {
        logic [1:0] reserved;
        logic b_in_en;
        logic a_in_en;
        logic [3:0] mode;
    } ipl_hold_cfg_t;

    typedef enum logic {
        IPL_IDLE = 1'b0,
        IPL_HELD = 1'b1
    } ipl_hold_state_t;

endpackage

// [logic/ipl_hold_stage.sv]
// Purpose: Applies the hold mode to one interrupt condition.
// Assumes: Condition and clear are synchronous to REF_CLK.
// Notes: Held output comes straight from the state flop.
`timescale 1ns/1ps
module ipl_hold_stage
    import ipl_pkg::*;
#(
    parameter int HOLD_BASE_CYC = IPL_HOLD_BASE_CYC
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic cond,
    input wire logic no_hold,
    input wire logic [3:0] mode,
    input wire logic clr,
    output logic held
);

    ipl_hold_state_t state_q;
    logic [31:0] cnt_q;
    logic [31:0] load_d;

    // Each code step doubles the base duration.
    assign load_d = 32'(HOLD_BASE_CYC) << (mode - IPL_MODE_STEP);
    assign held = (state_q == IPL_HELD);

    // Hold state machine; a new condition wins over a clear in the same cycle.
    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= IPL_IDLE;
            cnt_q <= 32'h0000_0000;
        end else if (no_hold || mode == IPL_MODE_NONLATCH) begin
            state_q <= cond ? IPL_HELD : IPL_IDLE;
            cnt_q <= 32'h0000_0000;
        end else if (mode == IPL_MODE_LATCHED) begin
            state_q <= (cond || (held && !clr)) ? IPL_HELD : IPL_IDLE;
            cnt_q <= 32'h0000_0000;
        end else begin
            case (state_q)
                IPL_IDLE: begin
                    if (cond) begin
                        state_q <= IPL_HELD;
                        cnt_q <= load_d;
                    end
                end
                IPL_HELD: begin
                    if (clr && cond) begin
                        cnt_q <= load_d;
                    end else if (clr || cnt_q <= 32'h0000_0001) begin
                        state_q <= IPL_IDLE;
                        cnt_q <= 32'h0000_0000;
                    end else begin
                        cnt_q <= cnt_q - 32'h0000_0001;
                    end
                end
                default: begin
                    state_q <= IPL_IDLE;
                    cnt_q <= 32'h0000_0000;
                end
            endcase
        end
    end

    logic temp_mode;
    assign temp_mode = !no_hold && mode != IPL_MODE_NONLATCH && mode != IPL_MODE_LATCHED;

    a_temp_keeps_held: assert property (@(posedge clk) disable iff (rst)
        temp_mode && held && cnt_q > 32'h0000_0001 && !clr && $stable(mode) |=> held)
        else $error("Timed hold released early.");

    a_temp_load_value: assert property (@(posedge clk) disable iff (rst)
        temp_mode && !held && cond |=> held && cnt_q == $past(load_d))
        else $error("Timed hold loaded wrong duration.");

endmodule

// [logic/ipl_pin_ctrl.sv]
// Purpose: Interrupt pin drive, polarity, input sensing and hold-mode control for two pins.
// Assumes: All inputs synchronous to REF_CLK; a byte register port reaches both registers.
// Notes: Pin index 0 is the first pin, index 1 the second; outputs are registered.
`timescale 1ns/1ps
module ipl_pin_ctrl
    import ipl_pkg::*;
#(
    parameter int HOLD_BASE_CYC = IPL_HOLD_BASE_CYC
) (
    input wire logic REF_CLK,
    input wire logic RST,
    input wire logic [7:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic REG_WE,
    input wire logic REG_RE,
    output logic [7:0] REG_RDATA,
    input wire logic [1:0] INT_COND,
    input wire logic [1:0] INT_NO_HOLD,
    input wire logic INT_CLEAR,
    input wire logic [1:0] PIN_IN,
    output logic [1:0] PIN_OUT,
    output logic [1:0] PIN_OE,
    output logic [1:0] TRIG_EVENT,
    output logic [1:0] FIFO_TAG
);

    ipl_out_cfg_t out_cfg_q;
    ipl_hold_cfg_t hold_cfg_q;
    logic [1:0] held;
    logic [1:0] act_q;
    logic [1:0] drive_en;
    logic [1:0] open_drain;
    logic [1:0] polarity;
    logic [1:0] edge_sel;
    logic [1:0] in_en;

    // Per-pin views of the configuration, index 0 for the first pin.
    assign drive_en = {out_cfg_q.b_drive, out_cfg_q.a_drive};
    assign open_drain = {out_cfg_q.b_open_drain, out_cfg_q.a_open_drain};
    assign polarity = {out_cfg_q.b_polarity, out_cfg_q.a_polarity};
    assign edge_sel = {out_cfg_q.b_edge, out_cfg_q.a_edge};
    assign in_en = {hold_cfg_q.b_in_en, hold_cfg_q.a_in_en};

    // Configuration writes; reserved hold bits stay zero so they read back as zero.
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            out_cfg_q <= IPL_OUT_CFG_RST;
            hold_cfg_q <= IPL_HOLD_RST;
        end else if (REG_WE) begin
            if (REG_ADDR == IPL_ADDR_OUT_CFG) begin
                out_cfg_q <= REG_WDATA;
            end
            if (REG_ADDR == IPL_ADDR_HOLD) begin
                hold_cfg_q <= REG_WDATA & IPL_HOLD_RW_MASK;
            end
        end
    end

    // Read data is registered; unmapped addresses return zero.
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            REG_RDATA <= 8'h00;
        end else if (REG_RE) begin
            case (REG_ADDR)
                IPL_ADDR_OUT_CFG: REG_RDATA <= out_cfg_q;
                IPL_ADDR_HOLD: REG_RDATA <= hold_cfg_q;
                default: REG_RDATA <= 8'h00;
            endcase
        end
    end

    // One hold stage and one pin driver per interrupt pin.
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_pin
            logic level;
            logic act_now;

            ipl_hold_stage #(
                .HOLD_BASE_CYC(HOLD_BASE_CYC)
            ) u_hold (
                .clk(REF_CLK),
                .rst(RST),
                .cond(INT_COND[gi]),
                .no_hold(INT_NO_HOLD[gi]),
                .mode(hold_cfg_q.mode),
                .clr(INT_CLEAR),
                .held(held[gi])
            );

            // Electrical pin level: asserted maps to high only when polarity is set.
            assign level = held[gi] ~^ polarity[gi];

            // Open drain releases the pin for a high level instead of driving it.
            always_ff @(posedge REF_CLK) begin
                if (RST) begin
                    PIN_OE[gi] <= 1'b0;
                    PIN_OUT[gi] <= 1'b0;
                end else begin
                    PIN_OE[gi] <= drive_en[gi] && !(open_drain[gi] && level);
                    PIN_OUT[gi] <= !open_drain[gi] && level;
                end
            end

            // Input trigger honours polarity only while the pin is not driven.
            assign act_now = PIN_IN[gi] ~^ polarity[gi];

            // Edge mode fires once per rise of the active level, level mode while it holds.
            always_ff @(posedge REF_CLK) begin
                if (RST) begin
                    act_q[gi] <= 1'b0;
                    TRIG_EVENT[gi] <= 1'b0;
                    FIFO_TAG[gi] <= 1'b0;
                end else begin
                    act_q[gi] <= act_now;
                    TRIG_EVENT[gi] <= in_en[gi] && !drive_en[gi] &&
                        (edge_sel[gi] ? (act_now && !act_q[gi]) : act_now);
                    FIFO_TAG[gi] <= in_en[gi] && PIN_IN[gi];
                end
            end
        end
    endgenerate

    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (RST);

    a_pin_b_off: assert property (
        !out_cfg_q.b_drive |=> !PIN_OE[1])
        else $error("Second pin driven while its output is disabled.");

    a_pin_a_off: assert property (
        !out_cfg_q.a_drive |=> !PIN_OE[0])
        else $error("First pin driven while its output is disabled.");

    a_open_drain_low: assert property (
        out_cfg_q.a_drive && out_cfg_q.a_open_drain |=> !PIN_OUT[0])
        else $error("Open-drain pin driven high.");

    a_push_pull_on: assert property (
        out_cfg_q.b_drive && !out_cfg_q.b_open_drain |=> PIN_OE[1])
        else $error("Push-pull pin not driven while enabled.");

    a_pin_b_level: assert property (
        out_cfg_q.b_drive && !out_cfg_q.b_open_drain |=>
        PIN_OUT[1] == ($past(held[1]) ~^ $past(out_cfg_q.b_polarity)))
        else $error("Second pin level disagrees with polarity.");

    a_pin_a_level: assert property (
        out_cfg_q.a_drive && !out_cfg_q.a_open_drain |=>
        PIN_OUT[0] == ($past(held[0]) ~^ $past(out_cfg_q.a_polarity)))
        else $error("First pin level disagrees with polarity.");

    a_tag_raw_level: assert property (
        hold_cfg_q.a_in_en |=> FIFO_TAG[0] == $past(PIN_IN[0]))
        else $error("Frame tag depends on more than the raw pin.");

    a_edge_single: assert property (
        out_cfg_q.a_edge && $stable(out_cfg_q) && TRIG_EVENT[0] |=> !TRIG_EVENT[0])
        else $error("Edge trigger fired on consecutive cycles.");

    // The trigger also needs the pin undriven, but the frame tag needs only the input enable.
    a_input_gate: assert property (
        !hold_cfg_q.b_in_en || out_cfg_q.b_drive |=> !TRIG_EVENT[1])
        else $error("Disabled input produced a trigger.");

    a_tag_gate: assert property (
        !hold_cfg_q.b_in_en |=> !FIFO_TAG[1])
        else $error("Disabled input produced a frame tag.");

    a_follow_cond: assert property (
        hold_cfg_q.mode == IPL_MODE_NONLATCH |=> held[0] == $past(INT_COND[0]))
        else $error("Non-latched interrupt does not follow its condition.");

    a_no_hold_kind: assert property (
        INT_NO_HOLD[1] |=> held[1] == $past(INT_COND[1]))
        else $error("Unholdable interrupt was held.");

    a_latch_stays: assert property (
        hold_cfg_q.mode == IPL_MODE_LATCHED && held[0] && !INT_CLEAR && !INT_NO_HOLD[0]
        |=> held[0])
        else $error("Latched interrupt released without a clear.");

    // The default disable would switch this check off exactly when it applies.
    a_reset_zero: assert property (@(posedge REF_CLK) disable iff (1'b0)
        RST |=> out_cfg_q == IPL_OUT_CFG_RST && hold_cfg_q == IPL_HOLD_RST && PIN_OE == 2'h0)
        else $error("Registers not zero after reset.");

endmodule

// [verif/ipl_far_end.sv]
// Purpose: Host side of the two interrupt pins, with board pull-up and a trigger source.
// Assumes: Source level and enable change on the falling clock edge.
// Notes: A released pin reads the enabled source level, else high through the pull-up, never the last value.
`timescale 1ns/1ps
module ipl_far_end (
    input wire logic [1:0] pin_out,
    input wire logic [1:0] pin_oe,
    input wire logic [1:0] src_lvl,
    input wire logic [1:0] src_en,
    output logic [1:0] pin_wire
);
    // Design drive wins, then the external source, then the pull-up.
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            pin_wire[i] = pin_oe[i] ? pin_out[i] : (src_en[i] ? src_lvl[i] : 1'b1);
        end
    end
endmodule

// [verif/ipl_pin_ctrl_test.sv]
// Purpose: Self-checking bench for the interrupt pin and hold-mode block.
// Assumes: Timed holds shortened through HOLD_BASE_CYC of 4.
// Notes: Inputs change on the falling edge; random data uses a fixed seed.
`timescale 1ns/1ps
module ipl_pin_ctrl_test;
    import ipl_pkg::*;
    localparam int HB = 4;
    logic clk = 1'b0, rst = 1'b1, we = 1'b0, re = 1'b0, clr = 1'b0;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
    logic [1:0] cond = 2'h0, nohold = 2'h0, slvl = 2'h0, sen = 2'h0;
    logic [1:0] pin, pout, poe, trig, tag;
    int failures = 0, tests_run = 0, seed = 32'hDA663FAC;

    ipl_pin_ctrl #(.HOLD_BASE_CYC(HB)) dut_u (.REF_CLK(clk), .RST(rst), .REG_ADDR(addr),
        .REG_WDATA(wdata), .REG_WE(we), .REG_RE(re), .REG_RDATA(rdata), .INT_COND(cond),
        .INT_NO_HOLD(nohold), .INT_CLEAR(clr), .PIN_IN(pin), .PIN_OUT(pout), .PIN_OE(poe),
        .TRIG_EVENT(trig), .FIFO_TAG(tag));
    ipl_far_end far_u (.pin_out(pout), .pin_oe(poe), .src_lvl(slvl), .src_en(sen),
        .pin_wire(pin));

    // A 4 ns clock; the watchdog cuts a hang short.
    initial forever #2 clk = ~clk;
    initial begin
        repeat (50000) @(negedge clk);
        failures++;
        wrap_up();
    end

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Strobes are lowered and one more edge passes, so back-to-back calls stay clean.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        addr = a;
        wdata = d;
        we = 1'b1;
        @(negedge clk);
        we = 1'b0;
        @(negedge clk);
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        addr = a;
        re = 1'b1;
        @(negedge clk);
        re = 1'b0;
        @(negedge clk);
        d = rdata;
    endtask

    // Expected {enable, wire level} of one pin for a held state.
    function automatic logic [1:0] pin_exp(input logic [7:0] c, input int i, input logic h);
        logic lvl;
        lvl = h ? c[4*i+1] : ~c[4*i+1];
        return {c[4*i+3] & (~c[4*i+2] | ~lvl), c[4*i+3] ? lvl : 1'b1};
    endfunction

    // One-cycle condition on both pins, then count active output cycles of the first.
    task automatic hold_run(input logic [3:0] m, input logic nh, output int n);
        int win;
        // The window spans a timed hold plus a margin, so a late release is seen.
        win = (m == IPL_MODE_NONLATCH || m == IPL_MODE_LATCHED) ? 300 : (HB << (m - 1)) + 44;
        wr(IPL_ADDR_HOLD, {4'h0, m});
        nohold = {nh, nh};
        cond = 2'b11;
        @(negedge clk);
        cond = 2'b00;
        n = 0;
        repeat (win) begin
            @(negedge clk);
            n += int'(pout[0] === 1'b1);
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d failures %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        logic [7:0] d, c;
        logic [1:0] e;
        int n;
        repeat (12) @(negedge clk);
        rst = 1'b0;
        check("outs_rst", {poe, pout, trig, tag}, 8'h00);
        rd(IPL_ADDR_OUT_CFG, d);
        check("out_cfg_rst", d, IPL_OUT_CFG_RST);
        rd(IPL_ADDR_HOLD, d);
        check("hold_rst", d, IPL_HOLD_RST);
        for (int k = 0; k < 6; k++) begin
            c = 8'($random(seed));
            wr(IPL_ADDR_HOLD, c);
            rd(IPL_ADDR_HOLD, d);
            check("hold_rw", d, c & IPL_HOLD_RW_MASK);
            wr(8'h55 + k[7:0], c);
            rd(8'h55 + k[7:0], d);
            check("unmapped", d, 8'h00);
        end
        // Output drive: corner configurations first, then random ones, follow mode.
        wr(IPL_ADDR_HOLD, 8'h00);
        for (int k = 0; k < 16; k++) begin
            c = (k < 2) ? (k == 0 ? 8'h88 : 8'hEE) : 8'($random(seed));
            wr(IPL_ADDR_OUT_CFG, c);
            rd(IPL_ADDR_OUT_CFG, d);
            check("out_cfg_rw", d, c);
            cond = 2'($random(seed));
            repeat (3) @(negedge clk);
            for (int i = 0; i < 2; i++) begin
                e = pin_exp(c, i, cond[i]);
                check("pin_oe", {7'h00, poe[i]}, {7'h00, e[1]});
                check("pin_lvl", {7'h00, pin[i]}, {7'h00, e[0]});
            end
        end
        // Hold modes on the first pin, push-pull and active high.
        cond = 2'b00;
        wr(IPL_ADDR_OUT_CFG, 8'h0A);
        hold_run(IPL_MODE_NONLATCH, 1'b0, n);
        check("follow", 8'(n), 8'h01);
        // The short codes one by one, then code 14, the longest timed hold.
        for (int m = 1; m < 15; m = (m == 8) ? 14 : m + 1) begin
            hold_run(4'(m), 1'b0, n);
            check("timed", 8'(n == (HB << (m - 1))), 8'h01);
        end
        hold_run(IPL_MODE_LATCHED, 1'b1, n);
        check("no_hold", 8'(n), 8'h01);
        hold_run(IPL_MODE_LATCHED, 1'b0, n);
        check("latched", 8'(n == 300), 8'h01);
        clr = 1'b1;
        @(negedge clk);
        clr = 1'b0;
        repeat (3) @(negedge clk);
        check("cleared", {7'h00, pout[0]}, 8'h00);
        // Input use: level sensing with random polarity, tag ignores polarity.
        nohold = 2'b00;
        sen = 2'b11;
        wr(IPL_ADDR_HOLD, 8'h30);
        for (int k = 0; k < 8; k++) begin
            c = 8'($random(seed)) & 8'h22;
            wr(IPL_ADDR_OUT_CFG, c);
            slvl = 2'($random(seed));
            @(negedge clk);
            check("trig_lvl", {6'h00, trig}, {6'h00, slvl ~^ {c[5], c[1]}});
            check("tag", {6'h00, tag}, {6'h00, slvl});
        end
        // Edge sensing, active high: one pulse per rise.
        slvl = 2'b00;
        wr(IPL_ADDR_OUT_CFG, 8'h33);
        slvl = 2'b11;
        @(negedge clk);
        check("edge_pulse", {6'h00, trig}, 8'h03);
        @(negedge clk);
        check("edge_end", {6'h00, trig}, 8'h00);
        wr(IPL_ADDR_HOLD, 8'h00);
        check("in_off", {4'h0, trig, tag}, 8'h00);
        // A reset in mid-run must clear a configuration that was written earlier.
        rst = 1'b1;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        check("outs_rst2", {poe, pout, trig, tag}, 8'h00);
        rd(IPL_ADDR_OUT_CFG, d);
        check("out_cfg_rst2", d, IPL_OUT_CFG_RST);
        wrap_up();
    end
endmodule
